// ---- core/fep_top.sv ----
// Flash erase/program sequencer with block protection and an APB slave.
// How it works
// - Mass erase refused unless protect byte is FF.
// - Mass erase sets every array byte to FF.
// - Programming works on aligned 32 byte rows.
// - Program select latches row address then byte data.
// - High voltage refused when target is protected.
// - Protected range runs from start to top.
// - Start address is 11, protect bits, six zeros.
// - 00 protects everything, FF protects nothing.
// - Beyond FF or FE, protect byte itself locked.
// - Test high voltage bypasses all block protection.
// - Protect byte changes only by programming or mass erase.
// - Unprotected protect byte is erased with array.
// - Wait mode aborts operation into standby.
// - Stop mode aborts operation into standby.
// - Standby drives all array controls inactive.
// - High voltage only after select and proper sequence.
// - Program and erase select are mutually exclusive.
module fep_top #(
   parameter logic [23:0] TME_DEF = fep_pkg::TME_CYC // Mass erase minimum.
) (
   input  wire logic          CLK_IN,       // 200 MHz bus clock.
   input  wire logic          SRST_IN,      // Synchronous reset, high.
   input  wire logic          PSEL_IN,      // APB select.
   input  wire logic          PENABLE_IN,   // APB access phase.
   input  wire logic          PWRITE_IN,    // APB direction.
   input  wire logic [7:0]    PADDR_IN,     // APB byte address.
   input  wire logic [31:0]   PWDATA_IN,    // APB write data.
   output logic               PREADY_OUT,   // APB ready.
   output logic [31:0]        PRDATA_OUT,   // APB read data.
   output logic               PSLVERR_OUT,  // APB error on unmapped address.
   input  wire logic          WAIT_MODE_IN, // CPU in wait mode.
   input  wire logic          STOP_MODE_IN, // CPU in stop mode.
   input  wire logic          TEST_HV_IN,   // Test high voltage on pin.
   input  wire logic [7:0]    PROT_BYTE_IN, // Stored protect byte value.
   output fep_pkg::fep_arr_t  ARR_OUT,      // Array command.
   output logic               BUSY_OUT      // Operation in progress.
);
   // Synchronisers for the asynchronous pin inputs.
   logic [1:0] wait_sync_reg;  // Wait mode synchroniser.
   logic [1:0] stop_sync_reg;  // Stop mode synchroniser.
   logic [1:0] tst_sync_reg;   // Test high voltage synchroniser.
   // Software visible state.
   logic       pgm_reg;        // Program select.
   logic       ers_reg;        // Erase select.
   logic       mass_reg;       // Mass select.
   logic       hv_reg;         // High voltage enable.
   logic       prot_rd_reg;    // Protect byte was read in this sequence.
   logic [15:0] addr_reg;      // Latched target address.
   logic [7:0]  data_reg;      // Latched program data.
   logic        refused_reg;   // Last high voltage request was refused.
   logic [23:0] nonvolatile_setup_time_reg;      // Setup minimum in cycles.
   logic [23:0] program_setup_time_reg;      // Program setup minimum in cycles.
   logic [23:0] byte_program_time_reg;     // Byte program minimum in cycles.
   logic [23:0] terase_reg;    // Mass erase minimum in cycles.
   logic [23:0] cnt_reg;       // Step timer.
   logic        time_ok_reg;   // Current step minimum has elapsed.
   fep_pkg::fep_state_t st_reg; // Sequencer state.
   // Decoded bus strobes and derived terms.
   logic        wr_en;         // Write access phase.
   logic        rd_en;         // Read access phase.
   logic        mapped;        // Address hits a register.
   logic        abort;         // Low power entry abort.
   logic        tgt_prot;      // Current target protected.
   logic        hv_try;        // Software tries to set high voltage.
   logic        hv_ok;         // High voltage allowed now.
   logic [31:0] rd_mux;        // Read data before the flop.
   logic [15:0] prot_base;     // Protect start address of the stored byte.

   // Protect start address from the protect bits.
   function automatic logic [15:0] prot_start(input logic [7:0] b);
      prot_start = {fep_pkg::PROT_TOP, b, fep_pkg::PROT_LOW};
   endfunction

   // True when an address lies in the protected range.
   function automatic logic is_prot(input logic [15:0] a,
                                    input logic [7:0] b,
                                    input logic tst);
      // All ones opens the whole array; the test voltage bypasses all.
      is_prot = !tst && (b != fep_pkg::PROT_OPEN)
                && (a >= prot_start(b));
   endfunction

   // Bus decode; the slave answers in the first access cycle.
   assign wr_en  = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign rd_en  = PSEL_IN && PENABLE_IN && !PWRITE_IN;
   assign mapped = PADDR_IN[1:0] == 2'h0 && PADDR_IN <= fep_pkg::TERASE_OFF;
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
   assign abort  = wait_sync_reg[1] || stop_sync_reg[1];

   // Protection of the target; the protect byte is locked once set hard.
   always_comb begin
      tgt_prot = is_prot(addr_reg, PROT_BYTE_IN, tst_sync_reg[1]);
      if (addr_reg == fep_pkg::PROT_ADDR && !tst_sync_reg[1]
          && PROT_BYTE_IN != fep_pkg::PROT_OPEN
          && PROT_BYTE_IN != fep_pkg::PROT_SOFT) begin
         tgt_prot = 1'b1;
      end
      // A mass erase is refused if any block is protected.
      if (ers_reg && mass_reg && !tst_sync_reg[1]
          && PROT_BYTE_IN != fep_pkg::PROT_OPEN) begin
         tgt_prot = 1'b1;
      end
   end

   // High voltage is accepted only in the target stage after setup time.
   assign hv_try = wr_en && PADDR_IN == fep_pkg::CTRL_OFF
                   && PWDATA_IN[fep_pkg::CTRL_HV] && !hv_reg;
   assign hv_ok  = (pgm_reg || ers_reg) && prot_rd_reg
                   && st_reg == fep_pkg::ST_TARGET && time_ok_reg
                   && !tgt_prot && !abort;

   // Pin synchronisers, two flops each.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         wait_sync_reg <= 2'h0;
         stop_sync_reg <= 2'h0;
         tst_sync_reg  <= 2'h0;
      end else begin
         wait_sync_reg <= {wait_sync_reg[0], WAIT_MODE_IN};
         stop_sync_reg <= {stop_sync_reg[0], STOP_MODE_IN};
         tst_sync_reg  <= {tst_sync_reg[0], TEST_HV_IN};
      end
   end

   // Control bits; select bits interlock and abort clears everything.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN || abort) begin
         pgm_reg  <= 1'b0;
         ers_reg  <= 1'b0;
         mass_reg <= 1'b0;
         hv_reg   <= 1'b0;
      end else if (wr_en && PADDR_IN == fep_pkg::CTRL_OFF) begin
         // A select is taken only when the other is and stays zero.
         if (!(PWDATA_IN[fep_pkg::CTRL_PGM]
               && PWDATA_IN[fep_pkg::CTRL_ERS])) begin
            pgm_reg <= PWDATA_IN[fep_pkg::CTRL_PGM] && !ers_reg;
            ers_reg <= PWDATA_IN[fep_pkg::CTRL_ERS] && !pgm_reg;
         end
         mass_reg <= PWDATA_IN[fep_pkg::CTRL_MASS];
         // Clearing is always allowed; setting needs the full sequence.
         if (!PWDATA_IN[fep_pkg::CTRL_HV]) begin
            hv_reg <= 1'b0;
         end else if (hv_try) begin
            hv_reg <= hv_ok;
         end
      end
   end

   // Refusal flag shows the last high voltage attempt outcome.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         refused_reg <= 1'b0;
      end else if (hv_try) begin
         refused_reg <= !hv_ok;
      end
   end

   // Protect byte read marker, reset whenever no select is set.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN || abort || !(pgm_reg || ers_reg)) begin
         prot_rd_reg <= 1'b0;
      end else if (rd_en && PADDR_IN == fep_pkg::PROT_OFF) begin
         prot_rd_reg <= 1'b1;
      end
   end

   // Programmable minimum step counts.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         nonvolatile_setup_time_reg   <= fep_pkg::NONVOLATILE_SETUP_TIME_CYC;
         program_setup_time_reg   <= fep_pkg::PROGRAM_SETUP_TIME_CYC;
         byte_program_time_reg  <= fep_pkg::BYTE_PROGRAM_TIME_CYC;
         terase_reg <= TME_DEF;
      end else if (wr_en) begin
         case (PADDR_IN)
            fep_pkg::NONVOLATILE_SETUP_TIME_OFF:   nonvolatile_setup_time_reg   <= PWDATA_IN[23:0];
            fep_pkg::PROGRAM_SETUP_TIME_OFF:   program_setup_time_reg   <= PWDATA_IN[23:0];
            fep_pkg::BYTE_PROGRAM_TIME_OFF:  byte_program_time_reg  <= PWDATA_IN[23:0];
            fep_pkg::TERASE_OFF: terase_reg <= PWDATA_IN[23:0];
            default: begin
            end
         endcase
      end
   end

   // Sequencer with step timer; the array write port is the data offset.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN || abort) begin
         st_reg      <= fep_pkg::ST_IDLE;
         cnt_reg     <= 24'h0;
         time_ok_reg <= 1'b0;
         addr_reg    <= 16'h0;
         data_reg    <= fep_pkg::ERASED;
      end else begin
         if (cnt_reg != 24'h0) begin
            cnt_reg <= cnt_reg - 24'h1;
         end
         time_ok_reg <= cnt_reg <= 24'h1;
         case (st_reg)
            fep_pkg::ST_IDLE: begin
               if (pgm_reg || ers_reg) begin
                  st_reg <= fep_pkg::ST_ARMED;
               end
            end
            fep_pkg::ST_ARMED: begin
               // First array write picks the target, then setup time runs.
               if (wr_en && PADDR_IN == fep_pkg::DATA_OFF) begin
                  addr_reg    <= PWDATA_IN[23:8];
                  cnt_reg     <= nonvolatile_setup_time_reg;
                  time_ok_reg <= 1'b0;
                  st_reg      <= fep_pkg::ST_TARGET;
               end else if (!(pgm_reg || ers_reg)) begin
                  st_reg <= fep_pkg::ST_IDLE;
               end
            end
            fep_pkg::ST_TARGET: begin
               if (hv_try && hv_ok) begin
                  cnt_reg     <= ers_reg ? terase_reg : program_setup_time_reg;
                  time_ok_reg <= 1'b0;
                  st_reg      <= fep_pkg::ST_HV;
               end else if (!(pgm_reg || ers_reg)) begin
                  st_reg <= fep_pkg::ST_IDLE;
               end
            end
            fep_pkg::ST_HV, fep_pkg::ST_BYTE: begin
               // Byte writes stay inside the latched row.
               if (pgm_reg && time_ok_reg && wr_en
                   && PADDR_IN == fep_pkg::DATA_OFF
                   && PWDATA_IN[23:8+fep_pkg::ROW_BITS]
                      == addr_reg[15:fep_pkg::ROW_BITS]) begin
                  addr_reg    <= PWDATA_IN[23:8];
                  data_reg    <= PWDATA_IN[7:0];
                  cnt_reg     <= byte_program_time_reg;
                  time_ok_reg <= 1'b0;
                  st_reg      <= fep_pkg::ST_BYTE;
               end
               if (!hv_reg) begin
                  st_reg <= fep_pkg::ST_IDLE;
               end
            end
            default: st_reg <= fep_pkg::ST_IDLE;
         endcase
      end
   end

   // Array command; all controls inactive outside an active step.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN || abort) begin
         ARR_OUT <= '0;
      end else begin
         ARR_OUT.hv    <= hv_reg;
         ARR_OUT.erase <= hv_reg && ers_reg;
         ARR_OUT.mass  <= hv_reg && ers_reg && mass_reg;
         ARR_OUT.prog  <= hv_reg && pgm_reg
                          && st_reg == fep_pkg::ST_BYTE && !time_ok_reg;
         ARR_OUT.addr  <= addr_reg;
         ARR_OUT.data  <= data_reg;
      end
   end

   // Read multiplexer; reserved bits read as zero.
   always_comb begin
      rd_mux = 32'h0;
      case (PADDR_IN)
         fep_pkg::CTRL_OFF:   rd_mux = {28'h0, hv_reg, mass_reg,
                                        ers_reg, pgm_reg};
         fep_pkg::PROT_OFF:   rd_mux = {24'h0, PROT_BYTE_IN};
         fep_pkg::ADDR_OFF:   rd_mux = {16'h0, addr_reg};
         fep_pkg::STAT_OFF:   rd_mux = {25'h0, tgt_prot, refused_reg,
                                        prot_rd_reg, time_ok_reg, st_reg};
         fep_pkg::NONVOLATILE_SETUP_TIME_OFF:   rd_mux = {8'h0, nonvolatile_setup_time_reg};
         fep_pkg::PROGRAM_SETUP_TIME_OFF:   rd_mux = {8'h0, program_setup_time_reg};
         fep_pkg::BYTE_PROGRAM_TIME_OFF:  rd_mux = {8'h0, byte_program_time_reg};
         fep_pkg::TERASE_OFF: rd_mux = {8'h0, terase_reg};
         default:             rd_mux = 32'h0;
      endcase
   end

   // Read data is registered at the setup phase for the access cycle.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         PRDATA_OUT <= 32'h0;
      end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
         PRDATA_OUT <= rd_mux;
      end
   end

   assign BUSY_OUT = hv_reg;

   // Start address as the protection check forms it, watched below.
   assign prot_base = prot_start(PROT_BYTE_IN);

   // A selected pair never both holds one.
   AST_SEL_EXCL: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      !(pgm_reg && ers_reg))
      else $error("select bits both set");
   // High voltage rises only from the target stage after the protect read.
   AST_HV_SEQ: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      $rose(hv_reg) |-> $past(st_reg) == fep_pkg::ST_TARGET
      && $past(prot_rd_reg))
      else $error("high voltage out of order");
   // A protected target never gets high voltage.
   AST_PROT_HV: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      $rose(hv_reg) |-> !$past(tgt_prot))
      else $error("protected hv");
   // Abort clears the array controls by the following cycle.
   AST_STANDBY: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      $rose(wait_sync_reg[1] || stop_sync_reg[1]) |=> ARR_OUT == '0)
      else $error("no standby after low power entry");
   // Voltage for a mass erase comes only with an open protect byte or the test voltage.
   AST_MASS_REF: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      $rose(hv_reg) && $past(ers_reg && mass_reg)
      |-> $past(tst_sync_reg[1])
      || $past(PROT_BYTE_IN) == fep_pkg::PROT_OPEN)
      else $error("mass erase not refused");
   // Start address form: ones on top, the protect bits, zeros below.
   AST_START: assert property (
      @(posedge CLK_IN)
      prot_base[15:14] == 2'h3 && prot_base[13:6] == PROT_BYTE_IN
      && prot_base[5:0] == 6'h0)
      else $error("bad protect start");
   // All zeros protects even the array base without test voltage.
   AST_ALL_PROT: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      PROT_BYTE_IN == 8'h00 && !tst_sync_reg[1]
      && addr_reg >= fep_pkg::ARRAY_BASE |-> tgt_prot)
      else $error("zero byte not protecting");
   // Program pulse stays off once the idle state has held for two cycles.
   AST_IDLE_QUIET: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      st_reg == fep_pkg::ST_IDLE ##1 st_reg == fep_pkg::ST_IDLE
      |-> !ARR_OUT.prog)
      else $error("program pulse in idle");
endmodule

// ---- pkg/fep_pkg.sv ----
// Package with constants and types for the flash erase/program/protect block.
package fep_pkg;
   // APB register byte offsets.
   localparam logic [7:0] CTRL_OFF    = 8'h00; // Array control register.
   localparam logic [7:0] PROT_OFF    = 8'h04; // Protect start byte (read only).
   localparam logic [7:0] ADDR_OFF    = 8'h08; // Latched target address.
   localparam logic [7:0] DATA_OFF    = 8'h0C; // Byte write port into the array.
   localparam logic [7:0] STAT_OFF    = 8'h10; // Sequencer status.
   localparam logic [7:0] NONVOLATILE_SETUP_TIME_OFF    = 8'h14; // Setup minimum count.
   localparam logic [7:0] PROGRAM_SETUP_TIME_OFF    = 8'h18; // Program setup minimum count.
   localparam logic [7:0] BYTE_PROGRAM_TIME_OFF   = 8'h1C; // Byte program minimum count.
   localparam logic [7:0] TERASE_OFF  = 8'h20; // Mass erase minimum count.
   // Control register bit positions.
   localparam int CTRL_PGM  = 0; // Program select.
   localparam int CTRL_ERS  = 1; // Erase select.
   localparam int CTRL_MASS = 2; // Mass select.
   localparam int CTRL_HV   = 3; // High voltage enable.
   // Protect byte layout and special values.
   localparam logic [7:0]  PROT_OPEN   = 8'hFF; // Nothing protected.
   localparam logic [7:0]  PROT_SOFT   = 8'hFE; // Still reprogrammable.
   localparam logic [1:0]  PROT_TOP    = 2'h3;  // Forced address bits 15:14.
   localparam logic [5:0]  PROT_LOW    = 6'h00; // Forced address bits 5:0.
   localparam logic [15:0] PROT_ADDR   = 16'hFF7E; // Where the byte lives.
   localparam logic [15:0] ARRAY_BASE  = 16'hC000; // First array address.
   localparam int          ROW_BITS    = 5;     // 32 byte rows.
   localparam logic [7:0]  ERASED      = 8'hFF; // Erased byte value.
   // Timing figures in ns and the 200 MHz period.
   localparam int CLK_NS   = 5;
   localparam int NONVOLATILE_SETUP_TIME_NS  = 10000;
   localparam int PROGRAM_SETUP_TIME_NS  = 5000;
   localparam int BYTE_PROGRAM_TIME_NS = 30000;
   localparam int TME_NS   = 4000000;
   localparam logic [23:0] NONVOLATILE_SETUP_TIME_CYC  = 24'((NONVOLATILE_SETUP_TIME_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [23:0] PROGRAM_SETUP_TIME_CYC  = 24'((PROGRAM_SETUP_TIME_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [23:0] BYTE_PROGRAM_TIME_CYC = 24'((BYTE_PROGRAM_TIME_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [23:0] TME_CYC   = 24'((TME_NS + CLK_NS - 1) / CLK_NS);
   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE, ST_ARMED, ST_TARGET, ST_HV, ST_BYTE
   } fep_state_t;
   // One array command towards the charge pump and cell array.
   typedef struct packed {
      logic        prog;  // Program pulse active.
      logic        erase; // Erase active.
      logic        mass;  // Whole array erase.
      logic        hv;    // Charge pump on.
      logic [15:0] addr;  // Target address.
      logic [7:0]  data;  // Byte to program.
   } fep_arr_t;
endpackage

// ---- verification/fep_flash_model.sv ----
// Behavioural flash cell array and charge pump facing the sequencer.
module fep_flash_model (
   input  wire logic              clk_in,        // Bus clock.
   input  wire fep_pkg::fep_arr_t arr_in,        // Array command.
   output logic [7:0]             prot_byte_out  // Stored protect byte.
);
   timeunit 1ns;
   timeprecision 100ps;
   // Cell array; an erased cell reads as all ones.
   logic [7:0] mem [16'hC000:16'hFFFF];

   // The protect byte is just one cell of the array.
   assign prot_byte_out = mem[fep_pkg::PROT_ADDR];

   // Start erased, as a blank part would be.
   initial begin
      foreach (mem[i]) mem[i] = fep_pkg::ERASED;
   end

   // The pump only acts while high voltage is on.
   always @(posedge clk_in) begin
      if (arr_in.hv && arr_in.erase && arr_in.mass) begin
         // The protect byte goes with the rest of the array.
         foreach (mem[i]) mem[i] = fep_pkg::ERASED;
      end else if (arr_in.hv && arr_in.prog &&
                   arr_in.addr >= fep_pkg::ARRAY_BASE) begin
         // A pulse can clear bits but never set them.
         mem[arr_in.addr] = mem[arr_in.addr] & arr_in.data;
      end
   end

   // Loads cell contents, standing in for an earlier programming run.
   task automatic preset(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask

   // Returns the present content of one cell.
   function automatic logic [7:0] peek(input logic [15:0] a);
      return mem[a];
   endfunction
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the flash erase/program/protect sequencer.
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin \
   err_count++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
   $time, act, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // Short minimum counts keep every wait brief.
   localparam int NONVOLATILE_SETUP_TIME = 20;
   localparam int PROGRAM_SETUP_TIME = 10;
   localparam int BYTE_PROGRAM_TIME = 30;
   localparam int TERASE = 40;
   logic              clk, srst, psel, penable, pwrite;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata;
   logic              pready, pslverr, wait_m, stop_m, test_hv, busy;
   logic [7:0]        prot;
   fep_pkg::fep_arr_t arr;
   int                err_count = 0;
   int                checked = 0;

   fep_top #(.TME_DEF(24'h000064)) u_fep_top (
      .CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
      .PSLVERR_OUT(pslverr), .WAIT_MODE_IN(wait_m),
      .STOP_MODE_IN(stop_m), .TEST_HV_IN(test_hv),
      .PROT_BYTE_IN(prot), .ARR_OUT(arr), .BUSY_OUT(busy));
   fep_flash_model u_fep_flash_model (
      .clk_in(clk), .arr_in(arr), .prot_byte_out(prot));

   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees ready.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   // Select, protect read, target write, setup wait, then voltage on.
   task automatic arm(input logic [3:0] sel, input logic [15:0] a,
                      input logic rd_prot);
      logic [31:0] q;
      wr(fep_pkg::CTRL_OFF, {28'h0, sel});
      if (rd_prot) rd(fep_pkg::PROT_OFF, q);
      wr(fep_pkg::DATA_OFF, {8'h00, a, 8'hFF});
      repeat (NONVOLATILE_SETUP_TIME + 10) @(posedge clk);
      wr(fep_pkg::CTRL_OFF, {28'h0, sel | 4'h8});
      repeat (3) @(posedge clk);
   endtask
   // Drop the selects first, hold, then the voltage.
   task automatic close;
      wr(fep_pkg::CTRL_OFF, 32'h00000008);
      repeat (10) @(posedge clk);
      wr(fep_pkg::CTRL_OFF, 32'h0);
      repeat (4) @(posedge clk);
   endtask
   // One attempt at a protected or open target.
   task automatic prot_case(input logic [7:0] p, input logic [15:0] a,
                            input logic tst, input logic exp);
      u_fep_flash_model.preset(fep_pkg::PROT_ADDR, p);
      test_hv <= tst;
      repeat (4) @(posedge clk);
      arm(4'h1, a, 1'b1);
      `CHK(busy, exp)
      close();
      test_hv <= 1'b0;
   endtask

   // Status after reset, timing counts, read-only byte, unmapped place.
   task automatic t_regs;
      logic [31:0] q;
      logic e;
      `CHK(busy, 1'b0)
      wr(fep_pkg::NONVOLATILE_SETUP_TIME_OFF, NONVOLATILE_SETUP_TIME);
      wr(fep_pkg::PROGRAM_SETUP_TIME_OFF, PROGRAM_SETUP_TIME);
      wr(fep_pkg::BYTE_PROGRAM_TIME_OFF, BYTE_PROGRAM_TIME);
      wr(fep_pkg::TERASE_OFF, TERASE);
      rd(fep_pkg::NONVOLATILE_SETUP_TIME_OFF, q);
      `CHK(q[7:0], 8'(NONVOLATILE_SETUP_TIME))
      wr(fep_pkg::PROT_OFF, 32'h0);
      rd(fep_pkg::PROT_OFF, q);
      `CHK(q[7:0], 8'hFF)
      `CHK(u_fep_flash_model.peek(fep_pkg::PROT_ADDR), 8'hFF)
      apb(1'b0, 8'h40, 32'h0, q, e);
      `CHK(e, 1'b1)
      $display("test regs done");
   endtask
   // Program and erase selects never stand together.
   task automatic t_interlock;
      logic [31:0] q;
      wr(fep_pkg::CTRL_OFF, 32'h00000003);
      rd(fep_pkg::CTRL_OFF, q);
      `CHK(q[1:0], 2'b00)
      wr(fep_pkg::CTRL_OFF, 32'h00000001);
      wr(fep_pkg::CTRL_OFF, 32'h00000003);
      rd(fep_pkg::CTRL_OFF, q);
      `CHK(q[1:0], 2'b01)
      wr(fep_pkg::CTRL_OFF, 32'h0);
      $display("test interlock done");
   endtask
   // Voltage without select, and without the protect read, is refused.
   task automatic t_no_read;
      logic [31:0] q;
      wr(fep_pkg::CTRL_OFF, 32'h00000008);
      repeat (3) @(posedge clk);
      `CHK(busy, 1'b0)
      arm(4'h1, 16'hC000, 1'b0);
      `CHK(busy, 1'b0)
      rd(fep_pkg::STAT_OFF, q);
      `CHK(q[5], 1'b1)
      wr(fep_pkg::CTRL_OFF, 32'h0);
      $display("test no_read done");
   endtask
   // Two bytes of one row, written back to back.
   task automatic t_program;
      arm(4'h1, 16'hC020, 1'b1);
      `CHK(busy, 1'b1)
      repeat (PROGRAM_SETUP_TIME + 5) @(posedge clk);
      wr(fep_pkg::DATA_OFF, 32'h00C0255A);
      repeat (BYTE_PROGRAM_TIME + 10) @(posedge clk);
      wr(fep_pkg::DATA_OFF, 32'h00C026A5);
      repeat (BYTE_PROGRAM_TIME + 10) @(posedge clk);
      close();
      `CHK(u_fep_flash_model.peek(16'hC025), 8'h5A)
      `CHK(u_fep_flash_model.peek(16'hC026), 8'hA5)
      $display("test program done");
   endtask
   // Start address boundaries, open and FE protect bytes, and test bypass.
   task automatic t_protect;
      prot_case(8'h01, 16'hC020, 1'b0, 1'b1);
      prot_case(8'h01, 16'hC040, 1'b0, 1'b0);
      prot_case(8'h80, 16'hDFE0, 1'b0, 1'b1);
      prot_case(8'h80, 16'hE000, 1'b0, 1'b0);
      prot_case(8'h00, 16'hC000, 1'b0, 1'b0);
      prot_case(8'hFF, 16'hFFE0, 1'b0, 1'b1);
      prot_case(8'hFE, 16'hFF60, 1'b0, 1'b1);
      prot_case(8'hFD, 16'hFF60, 1'b0, 1'b0);
      prot_case(8'h00, 16'hC000, 1'b1, 1'b1);
      $display("test protect done");
   endtask
   // Mass erase refused under protection, else clears everything.
   task automatic t_mass;
      u_fep_flash_model.preset(fep_pkg::PROT_ADDR, 8'hFE);
      arm(4'h6, 16'hC000, 1'b1);
      `CHK(busy, 1'b0)
      wr(fep_pkg::CTRL_OFF, 32'h0);
      u_fep_flash_model.preset(fep_pkg::PROT_ADDR, 8'hFF);
      u_fep_flash_model.preset(16'hC000, 8'h00);
      u_fep_flash_model.preset(16'hFFC0, 8'h12);
      arm(4'h6, fep_pkg::PROT_ADDR, 1'b1);
      `CHK(busy, 1'b1)
      repeat (120) @(posedge clk);
      close();
      `CHK(u_fep_flash_model.peek(16'hC000), 8'hFF)
      `CHK(u_fep_flash_model.peek(16'hFFC0), 8'hFF)
      `CHK(prot, 8'hFF)
      $display("test mass done");
   endtask
   // Wait, then stop, in mid-program drop the array to standby.
   task automatic t_abort;
      logic [31:0] q;
      for (int i = 0; i < 2; i++) begin
         arm(4'h1, 16'hC0A0, 1'b1);
         `CHK(busy, 1'b1)
         if (i == 0) wait_m <= 1'b1;
         else stop_m <= 1'b1;
         repeat (6) @(posedge clk);
         `CHK(busy, 1'b0)
         `CHK({arr.prog, arr.erase, arr.hv}, 3'b000)
         rd(fep_pkg::CTRL_OFF, q);
         `CHK(q[3:0], 4'h0)
         wait_m <= 1'b0;
         stop_m <= 1'b0;
         repeat (4) @(posedge clk);
      end
      $display("test abort done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // The whole run needs well under 10000 cycles; this cuts a hang.
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
   // Reset, then the scenarios in turn.
   initial begin
      {srst, psel, penable, pwrite} <= 4'h8;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      {wait_m, stop_m, test_hv} <= 3'h0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_interlock();
      t_no_read();
      t_program();
      t_protect();
      t_mass();
      t_abort();
      complete_run();
   end
endmodule
